// File: hw/host_bus_decode_pkg.sv
// Behaviour
// - claim exactly sixteen I/O bytes at base
// - factory straps decode I/O at 250h
// - five of six straps pick base 200h-3FFh, open=one
// - 8K memory inside 16K upper window
// - three straps pick C0000-DC000, inserted=one
// - factory memory straps give window CC000
// - interrupt on acquisition done when enabled
// - tristate interrupt, released when not asserting
// - one-hot straps route to 2,5,7,10,11,12,15
// - no strap inserted leaves lines undriven
package host_bus_decode_pkg;
  localparam int IO_ADDR_W      = 10;
  localparam int MEM_ADDR_W     = 20;
  localparam int IO_STRAP_W     = 6;
  localparam int MEM_STRAP_W    = 3;
  localparam int IRQ_STRAP_W    = 7;
  localparam int IO_BLOCK_LSB   = 4;
  localparam int MEM_WIN_LSB    = 14;
  localparam int BUF_ADDR_W     = 13;
  localparam logic [2:0] UMB_TOP_PATTERN = 3'h6;
  localparam logic [0:0] IO_BASE_BIT9    = 1'h1;
  // straps are active-low "inserted" sense: 1 = jumper out
  localparam logic [IO_STRAP_W-1:0]  IO_STRAP_FACTORY  = 6'h25;
  // position 1 out, positions 2 and 3 in: window bits 16..14 read 011
  localparam logic [MEM_STRAP_W-1:0] MEM_STRAP_FACTORY = 3'h4;
  localparam logic [IRQ_STRAP_W-1:0] IRQ_STRAP_FACTORY = 7'h00;
  localparam logic [IO_ADDR_W-1:0]   IO_BASE_FACTORY   = 10'h250;
  localparam logic [MEM_ADDR_W-1:0]  MEM_BASE_FACTORY  = 20'hCC000;
endpackage

// File: hw/irq_route.sv
`timescale 1ns/10ps
module irq_route
  import host_bus_decode_pkg::*;
(
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_sys_rst,
  input  wire logic                   i_req,
  input  wire logic [IRQ_STRAP_W-1:0] i_sel,
  output logic      [IRQ_STRAP_W-1:0] o_irq,
  output logic      [IRQ_STRAP_W-1:0] o_irq_oe_n
);
  logic [IRQ_STRAP_W-1:0] oe_n_r;
  logic [IRQ_STRAP_W-1:0] oe_n_nxt;
  logic                   onehot;

  always_comb begin
    onehot   = (i_sel != '0) && ((i_sel & (i_sel - 1'b1)) == '0);
    oe_n_nxt = '1;
    if (onehot && i_req) begin
      oe_n_nxt = ~i_sel;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      oe_n_r <= '1;
    end else begin
      oe_n_r <= oe_n_nxt;
    end
  end

  assign o_irq      = ~oe_n_r;
  assign o_irq_oe_n = oe_n_r;
endmodule

// File: hw/host_bus_decode_and_irq_select.sv
`timescale 1ns/10ps
module host_bus_decode_and_irq_select
  import host_bus_decode_pkg::*;
(
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_sys_rst,
  input  wire logic [IO_ADDR_W-1:0]   i_io_addr,
  input  wire logic                   i_io_cycle,
  input  wire logic [MEM_ADDR_W-1:0]  i_mem_addr,
  input  wire logic                   i_mem_cycle,
  input  wire logic [IO_STRAP_W-1:0]  i_io_base_select_straps,
  input  wire logic [MEM_STRAP_W-1:0] i_mem_window_select_straps,
  input  wire logic [IRQ_STRAP_W-1:0] i_irq_line_select_straps,
  input  wire logic                   i_irq_enable,
  input  wire logic                   i_acq_done,
  input  wire logic                   i_irq_ack,
  output logic                        o_io_sel,
  output logic [IO_BLOCK_LSB-1:0]     o_io_offset,
  output logic                        o_mem_sel,
  output logic [BUF_ADDR_W-1:0]       o_buf_addr,
  output logic                        o_irq_pending,
  output logic [IRQ_STRAP_W-1:0]      o_irq,
  output logic [IRQ_STRAP_W-1:0]      o_irq_oe_n
);
  // io decode group
  logic                    io_sel_r;
  logic                    io_sel_nxt;
  logic [IO_BLOCK_LSB-1:0] io_off_r;
  logic [IO_BLOCK_LSB-1:0] io_off_nxt;
  logic [IO_ADDR_W-1:0]    io_base;
  logic                    io_hit;

  // memory window group
  logic                    mem_sel_r;
  logic                    mem_sel_nxt;
  logic [BUF_ADDR_W-1:0]   buf_addr_r;
  logic [BUF_ADDR_W-1:0]   buf_addr_nxt;
  logic [MEM_ADDR_W-1:0]   mem_base;
  logic                    mem_hit;

  // interrupt group
  logic                    pend_r;
  logic                    pend_nxt;
  logic                    pend_set;
  logic                    pend_clr;

  // straps: position 1 is always open; positions 2..6 map to bits 8..4, open = 1
  function automatic logic [IO_ADDR_W-1:0] io_base_of(
    input logic [IO_STRAP_W-1:0] s
  );
    return {IO_BASE_BIT9, s[IO_STRAP_W-2:0], {IO_BLOCK_LSB{1'b0}}};
  endfunction

  // inserted strap = 1, position 1 heaviest; straps arrive as 1 = jumper out
  function automatic logic [MEM_ADDR_W-1:0] mem_base_of(
    input logic [MEM_STRAP_W-1:0] s
  );
    return {UMB_TOP_PATTERN, ~s, {MEM_WIN_LSB{1'b0}}};
  endfunction

  // block match ignores the offset bits below the block size
  function automatic logic io_match(
    input logic [IO_ADDR_W-1:0] a,
    input logic [IO_ADDR_W-1:0] b
  );
    logic [IO_ADDR_W-IO_BLOCK_LSB-1:0] a_blk;
    logic [IO_ADDR_W-IO_BLOCK_LSB-1:0] b_blk;
    a_blk = a[IO_ADDR_W-1:IO_BLOCK_LSB];
    b_blk = b[IO_ADDR_W-1:IO_BLOCK_LSB];
    return a_blk == b_blk;
  endfunction

  // window match ignores the offset bits below the window size
  function automatic logic mem_match(
    input logic [MEM_ADDR_W-1:0] a,
    input logic [MEM_ADDR_W-1:0] b
  );
    logic [MEM_ADDR_W-MEM_WIN_LSB-1:0] a_win;
    logic [MEM_ADDR_W-MEM_WIN_LSB-1:0] b_win;
    a_win = a[MEM_ADDR_W-1:MEM_WIN_LSB];
    b_win = b[MEM_ADDR_W-1:MEM_WIN_LSB];
    return a_win == b_win;
  endfunction

  // byte offset inside the claimed io block
  function automatic logic [IO_BLOCK_LSB-1:0] io_offset_of(
    input logic [IO_ADDR_W-1:0] a
  );
    return a[IO_BLOCK_LSB-1:0];
  endfunction

  // 8K buffer aliases twice across the 16K window
  function automatic logic [BUF_ADDR_W-1:0] buf_offset_of(
    input logic [MEM_ADDR_W-1:0] a
  );
    return a[BUF_ADDR_W-1:0];
  endfunction

  // io decode: straps are read again on every bus cycle, nothing is latched,
  // so a strap change takes effect on the next cycle without a reset
  always_comb begin
    io_base    = io_base_of(i_io_base_select_straps);
    io_hit     = i_io_cycle && io_match(i_io_addr, io_base);
    io_sel_nxt = io_hit;
    io_off_nxt = io_off_r;
    if (io_hit) begin
      io_off_nxt = io_offset_of(i_io_addr);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      io_sel_r <= 1'b0;
      io_off_r <= '0;
    end else begin
      io_sel_r <= io_sel_nxt;
      io_off_r <= io_off_nxt;
    end
  end

  // memory window decode: top three bits are the fixed upper-memory pattern
  always_comb begin
    mem_base     = mem_base_of(i_mem_window_select_straps);
    mem_hit      = i_mem_cycle && mem_match(i_mem_addr, mem_base);
    mem_sel_nxt  = mem_hit;
    buf_addr_nxt = buf_addr_r;
    if (mem_hit) begin
      buf_addr_nxt = buf_offset_of(i_mem_addr);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      mem_sel_r  <= 1'b0;
      buf_addr_r <= '0;
    end else begin
      mem_sel_r  <= mem_sel_nxt;
      buf_addr_r <= buf_addr_nxt;
    end
  end

  // interrupt pending: a completion sets it, acknowledge clears it;
  // a completion in the same cycle as an acknowledge is kept, so no
  // end of acquisition is lost; dropping the enable clears it at once
  always_comb begin
    pend_set = i_acq_done && i_irq_enable;
    pend_clr = i_irq_ack || !i_irq_enable;
    pend_nxt = pend_r;
    if (pend_clr) begin
      pend_nxt = 1'b0;
    end
    if (pend_set) begin
      pend_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      pend_r <= 1'b0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // line routing and release live in their own block; a bad strap
  // pattern there leaves every line undriven
  irq_route u_irq_route (
    .i_clk_sys  (i_clk_sys),
    .i_sys_rst  (i_sys_rst),
    .i_req      (pend_r),
    .i_sel      (i_irq_line_select_straps),
    .o_irq      (o_irq),
    .o_irq_oe_n (o_irq_oe_n)
  );

  // every data output comes straight from a flip-flop
  assign o_io_sel      = io_sel_r;
  assign o_io_offset   = io_off_r;
  assign o_mem_sel     = mem_sel_r;
  assign o_buf_addr    = buf_addr_r;
  assign o_irq_pending = pend_r;

  // notes for users of this block:
  // the io strobe and offset follow the bus cycle by one clock;
  // the window strobe and buffer address follow it by one clock;
  // the buffer offset repeats in both halves of the window;
  // the offsets hold their last claimed value between hits;
  // the interrupt line follows the pending flag by one clock;
  // position 1 of the io straps has no effect on the decode;
  // io bit 9 is always one, so the block sits in 200h..3FFh;
  // the window always sits between C0000 and DFFFF;
  // straps may change at any time, the decode follows them;
  // the pending flag is only cleared by acknowledge, disable or reset;
  // the bus cycle flags qualify every decode, stray addresses are ignored;
  // nothing here drives data onto the host bus itself;
  // the register contents behind these strobes live elsewhere.
endmodule

// File: testbench/irq_wire_model.sv
`timescale 1ns/10ps
module irq_wire_model (
  input  logic [6:0] i_irq, i_oe_n,
  output logic [6:0] o_line
);
  // a released line sits at the host pull-down level
  assign o_line = i_irq & ~i_oe_n;
endmodule

// File: testbench/decode_asserts.sv
`timescale 1ns/10ps
module dchk
  import host_bus_decode_pkg::*;
(
  input logic i_clk_sys, i_sys_rst, i_io_cycle, i_mem_cycle, i_irq_enable, i_acq_done,
  input logic o_io_sel, o_mem_sel, o_irq_pending,
  input logic [9:0] i_io_addr,
  input logic [19:0] i_mem_addr,
  input logic [5:0] i_io_base_select_straps,
  input logic [2:0] i_mem_window_select_straps,
  input logic [6:0] i_irq_line_select_straps, o_irq_oe_n
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  wire io_hit = i_io_cycle && i_io_addr[9:4] == {1'h1, i_io_base_select_straps[4:0]};
  wire mem_hit = i_mem_cycle && i_mem_addr[19:14] == {3'h6, ~i_mem_window_select_straps};
  wire [6:0] sel = i_irq_line_select_straps;
  property p_ioh; io_hit |=> o_io_sel; endproperty
  a_ioh: assert property (p_ioh) else $error("io miss");
  property p_iom; !io_hit |=> !o_io_sel; endproperty
  a_iom: assert property (p_iom) else $error("io false");
  property p_mh; mem_hit |=> o_mem_sel; endproperty
  a_mh: assert property (p_mh) else $error("mem miss");
  property p_mm; !mem_hit |=> !o_mem_sel; endproperty
  a_mm: assert property (p_mm) else $error("mem false");
  property p_set; i_acq_done && i_irq_enable |=> o_irq_pending; endproperty
  a_set: assert property (p_set) else $error("no pend");
  property p_off; !i_irq_enable |=> !o_irq_pending; endproperty
  a_off: assert property (p_off) else $error("pend off");
  property p_drv; o_irq_pending && $onehot(sel) |=> o_irq_oe_n == ~$past(sel); endproperty
  a_drv: assert property (p_drv) else $error("drive");
  property p_rel; !o_irq_pending || !$onehot(sel) |=> &o_irq_oe_n; endproperty
  a_rel: assert property (p_rel) else $error("release");
  c_io: cover property (io_hit);
  c_mem: cover property (mem_hit);
  c_irq: cover property (!(&o_irq_oe_n));
endmodule
bind host_bus_decode_and_irq_select dchk dchk_i (.*);

// File: testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
  import host_bus_decode_pkg::*;
  logic i_clk_sys, i_sys_rst, i_io_cycle, i_mem_cycle, i_irq_enable, i_acq_done, i_irq_ack;
  logic o_io_sel, o_mem_sel, o_irq_pending, eio, ems, epd;
  logic [9:0] i_io_addr;
  logic [19:0] i_mem_addr;
  logic [5:0] i_io_base_select_straps;
  logic [2:0] i_mem_window_select_straps;
  logic [6:0] i_irq_line_select_straps, o_irq, o_irq_oe_n, line, eoe;
  logic [3:0] o_io_offset, eof;
  logic [12:0] o_buf_addr, eba;
  int n_errors, comparisons;
  int unsigned r = 92;
  host_bus_decode_and_irq_select host_bus_decode_and_irq_select_i (.*);
  irq_wire_model irq_wire_model_i (.i_irq(o_irq), .i_oe_n(o_irq_oe_n), .o_line(line));
  task automatic chk(input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    i_clk_sys = 0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    #100us;
    n_errors++;
    tally_and_finish;
  end
  initial begin
    {i_sys_rst, i_io_cycle, i_mem_cycle, i_irq_enable, i_acq_done, i_irq_ack} = 6'h20;
    {i_io_addr, i_mem_addr} = 30'h0;
    i_io_base_select_straps = IO_STRAP_FACTORY;
    i_mem_window_select_straps = MEM_STRAP_FACTORY;
    i_irq_line_select_straps = IRQ_STRAP_FACTORY;
    for (int n = 0; n < 4000; n++) begin
      @(posedge i_clk_sys);
      if (i_sys_rst) {eio, ems, epd, eof, eba, eoe} = {3'h0, 17'h0, 7'h7F};
      else begin
        eoe = epd && $onehot(i_irq_line_select_straps) ? ~i_irq_line_select_straps : 7'h7F;
        epd = i_acq_done && i_irq_enable || epd && i_irq_enable && !i_irq_ack;
        eio = i_io_cycle && i_io_addr[9:4] == {1'h1, i_io_base_select_straps[4:0]};
        ems = i_mem_cycle && i_mem_addr[19:14] == {3'h6, ~i_mem_window_select_straps};
        if (eio) eof = i_io_addr[3:0];
        if (ems) eba = i_mem_addr[12:0];
      end
      r ^= r << 13;
      r ^= r >> 17;
      r ^= r << 5;
      i_sys_rst <= n < 1;
      {i_io_cycle, i_mem_cycle, i_irq_enable} <= {r[0], r[1], r[4:2] != 3'h0};
      {i_acq_done, i_irq_ack} <= {r[5] & r[6], r[7] & r[8]};
      i_io_addr <= r[9] ? {1'h1, i_io_base_select_straps[4:0], r[13:10]} : r[31:22];
      i_mem_addr <= r[14] ? {3'h6, ~i_mem_window_select_straps, r[31:18]} : r[31:12];
      if (n % 500 == 499) begin
        i_io_base_select_straps <= r[21:16];
        i_mem_window_select_straps <= r[18:16];
        i_irq_line_select_straps <= r[22:20] < 7 ? 7'h01 << r[22:20] : {r[23], 5'h0, r[23]};
      end
      #1;
      chk({o_io_sel, o_io_offset}, {eio, eof});
      chk({o_mem_sel, o_buf_addr}, {ems, eba});
      chk({o_irq_pending, o_irq, o_irq_oe_n, line}, {epd, ~eoe, eoe, ~eoe});
    end
    tally_and_finish;
  end
endmodule
